/* File: core/bfh_host.sv */
// Host controller driving a dual-width boot-block flash over its parallel pins
`timescale 1ns/1ps
`default_nettype none
module bfh_host
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // Request side
    input  wire logic                 reqValid,
    input  wire bfh_pkg::bfh_op_type  reqOp,
    input  wire logic [19:0]          reqAddr,
    input  wire logic [15:0]          reqData,
    input  wire logic                 reqWordMode,
    input  wire logic                 reqBootUnlock,
    input  wire logic                 reqIdByVoltage,
    output logic                      reqReady,
    output logic                      rspValid,
    output logic [15:0]               rspData,
    // Flash pins
    output logic [18:0]               flashAddr,
    output logic [15:0]               flashDqOut,
    output logic [15:0]               flashDqOe,
    input  wire logic [15:0]          flashDqIn,
    output logic                      flashCeN,
    output logic                      flashOeN,
    output logic                      flashWeN,
    output logic                      flashWpN,
    output logic                      flashByteN,
    output logic                      resetPowerdownN,
    output logic                      bootUnlockHighVoltage,
    output logic                      idAccessHighVoltage,
    output logic                      programSupplyHighLevel
);
    import bfh_pkg::*;

    // Command byte on low lanes, upper lanes zero
    function automatic logic [15:0] cmdWord(input logic [7:0] c);
        cmdWord = {8'h00, c};
    endfunction

    // Write lane enables: all lines in word mode, low byte plus line 15 in byte mode
    function automatic logic [15:0] writeLanes(input logic w);
        writeLanes = w ? 16'hFFFF : 16'h80FF;
    endfunction

    bfh_state_type stateReg, stateNext;
    logic [3:0]    cntReg, cntNext;
    bfh_op_type    opReg, opNext;
    logic [19:0]   addrReg, addrNext;
    logic [15:0]   dataReg, dataNext;
    logic          wordReg, wordNext;
    logic          unlockReg, unlockNext;
    logic          idVReg, idVNext;
    logic [18:0]   aReg, aNext;
    logic [15:0]   dqReg, dqNext;
    logic [15:0]   oeReg, oeNext;
    logic          ceReg, ceNext, oeNReg, oeNNext, weReg, weNext;
    logic          wpReg, wpNext, hhReg, hhNext, vidReg, vidNext, vppReg, vppNext;
    logic          rdyReg, rdyNext, rvReg, rvNext;
    logic [15:0]   rdReg, rdNext;
    logic          rpReg;
    logic [15:0]   dqSync1Reg, dqSync2Reg;

    // Pin inputs through two flops
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dqSync1Reg <= ZERO_WORD;
            dqSync2Reg <= ZERO_WORD;
        end else begin
            dqSync1Reg <= flashDqIn;
            dqSync2Reg <= dqSync1Reg;
        end
    end

    // Sequencer next-state
    always_comb begin
        stateNext  = stateReg;
        cntNext    = cntReg;
        opNext     = opReg;
        addrNext   = addrReg;
        dataNext   = dataReg;
        wordNext   = wordReg;
        unlockNext = unlockReg;
        idVNext    = idVReg;
        aNext      = aReg;
        dqNext     = dqReg;
        oeNext     = oeReg;
        ceNext     = ceReg;
        oeNNext    = oeNReg;
        weNext     = weReg;
        wpNext     = wpReg;
        hhNext     = hhReg;
        vidNext    = vidReg;
        vppNext    = vppReg;
        rdyNext    = rdyReg;
        rvNext     = 1'b0;
        rdNext     = rdReg;
        unique case (stateReg)
            ST_IDLE: begin
                rdyNext = 1'b1;
                if (reqValid && rdyReg) begin
                    rdyNext    = 1'b0;
                    opNext     = reqOp;
                    addrNext   = reqAddr;
                    dataNext   = reqData;
                    wordNext   = reqWordMode;
                    unlockNext = reqBootUnlock;
                    idVNext    = reqIdByVoltage;
                    // Word mode: A0..A18 from addr[19:1]; byte mode adds addr[0] on DQ15
                    aNext      = reqAddr[19:1];
                    ceNext     = 1'b0;
                    cntNext    = STROBE_CYC;
                    if (reqOp == OP_READ || (reqOp == OP_IDENT && reqIdByVoltage)) begin
                        if (reqOp == OP_IDENT) begin
                            aNext   = {9'h000, 1'b1, 8'h00, reqAddr[0]};
                            vidNext = 1'b1;
                        end
                        oeNNext   = 1'b0;
                        // Only DQ15 driven as address in byte mode
                        oeNext    = reqWordMode ? ZERO_WORD : 16'h8000;
                        dqNext    = reqWordMode ? ZERO_WORD : {reqAddr[0], 15'h0000};
                        stateNext = ST_RD;
                    end else begin
                        weNext    = 1'b0;
                        oeNext    = writeLanes(reqWordMode);
                        unique case (reqOp)
                            OP_ERASE:   dqNext = cmdWord(CMD_ERASE_SETUP);
                            OP_PROGRAM: dqNext = cmdWord(CMD_WRITE_SETUP);
                            OP_RDARRAY: dqNext = cmdWord(CMD_READ_ARRAY);
                            default:    dqNext = cmdWord(CMD_IDENTIFY);
                        endcase
                        stateNext = ST_WR1;
                    end
                end
            end
            ST_WR1: begin
                cntNext = cntReg - ONE_CYC;
                if (cntReg == ONE_CYC) begin
                    weNext = 1'b1;
                    ceNext = 1'b1;
                    cntNext = RECOVER_CYC;
                    if (opReg == OP_ERASE || opReg == OP_PROGRAM || opReg == OP_IDENT) begin
                        stateNext = ST_GAP;
                    end else begin
                        stateNext = ST_DONE;
                    end
                end
            end
            ST_GAP: begin
                cntNext = cntReg - ONE_CYC;
                if (cntReg == ONE_CYC) begin
                    ceNext  = 1'b0;
                    cntNext = STROBE_CYC;
                    if (opReg == OP_IDENT) begin
                        // Identify read follows the command, no high voltage
                        aNext     = {18'h0, addrReg[0]};
                        oeNext    = wordReg ? ZERO_WORD : 16'h8000;
                        oeNNext   = 1'b0;
                        stateNext = ST_RD;
                    end else begin
                        weNext  = 1'b0;
                        vppNext = 1'b1;
                        wpNext  = unlockReg;
                        hhNext  = unlockReg;
                        if (opReg == OP_ERASE) begin
                            dqNext = cmdWord(CMD_CONFIRM);
                            oeNext = writeLanes(wordReg);
                        end else if (wordReg) begin
                            dqNext = dataReg;
                            oeNext = 16'hFFFF;
                        end else begin
                            dqNext = {addrReg[0], 7'h00, dataReg[7:0]};
                            oeNext = 16'h80FF;
                        end
                        stateNext = ST_WR2;
                    end
                end
            end
            ST_WR2: begin
                cntNext = cntReg - ONE_CYC;
                if (cntReg == ONE_CYC) begin
                    weNext    = 1'b1;
                    ceNext    = 1'b1;
                    cntNext   = RECOVER_CYC;
                    stateNext = ST_DONE;
                end
            end
            ST_RD: begin
                cntNext = cntReg - ONE_CYC;
                if (cntReg == ONE_CYC) begin
                    // Byte mode keeps only the low lane
                    rdNext    = wordReg ? dqSync2Reg : {8'h00, dqSync2Reg[7:0]};
                    rvNext    = 1'b1;
                    oeNNext   = 1'b1;
                    ceNext    = 1'b1;
                    vidNext   = 1'b0;
                    cntNext   = RECOVER_CYC;
                    stateNext = ST_DONE;
                end
            end
            ST_DONE: begin
                oeNext  = ZERO_WORD;
                vppNext = 1'b0;
                wpNext  = 1'b0;
                hhNext  = 1'b0;
                cntNext = cntReg - ONE_CYC;
                if (cntReg == ONE_CYC) begin
                    rdyNext   = 1'b1;
                    stateNext = ST_IDLE;
                end
            end
            default: stateNext = ST_IDLE;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stateReg  <= ST_IDLE;
            cntReg    <= 4'h0;
            opReg     <= OP_READ;
            addrReg   <= 20'h00000;
            dataReg   <= ZERO_WORD;
            wordReg   <= 1'b1;
            unlockReg <= 1'b0;
            idVReg    <= 1'b0;
            aReg      <= 19'h00000;
            dqReg     <= ZERO_WORD;
            oeReg     <= ZERO_WORD;
            ceReg     <= 1'b1;
            oeNReg    <= 1'b1;
            weReg     <= 1'b1;
            wpReg     <= 1'b0;
            hhReg     <= 1'b0;
            vidReg    <= 1'b0;
            vppReg    <= 1'b0;
            rdyReg    <= 1'b0;
            rvReg     <= 1'b0;
            rdReg     <= ZERO_WORD;
            rpReg     <= 1'b0;
        end else begin
            stateReg  <= stateNext;
            cntReg    <= cntNext;
            opReg     <= opNext;
            addrReg   <= addrNext;
            dataReg   <= dataNext;
            wordReg   <= wordNext;
            unlockReg <= unlockNext;
            idVReg    <= idVNext;
            aReg      <= aNext;
            dqReg     <= dqNext;
            oeReg     <= oeNext;
            ceReg     <= ceNext;
            oeNReg    <= oeNNext;
            weReg     <= weNext;
            wpReg     <= wpNext;
            hhReg     <= hhNext;
            vidReg    <= vidNext;
            vppReg    <= vppNext;
            rdyReg    <= rdyNext;
            rvReg     <= rvNext;
            rdReg     <= rdNext;
            rpReg     <= 1'b1;
        end
    end

    // Outputs straight from flops
    assign reqReady               = rdyReg;
    assign rspValid               = rvReg;
    assign rspData                = rdReg;
    assign flashAddr              = aReg;
    assign flashDqOut             = dqReg;
    assign flashDqOe              = oeReg;
    assign flashCeN               = ceReg;
    assign flashOeN               = oeNReg;
    assign flashWeN               = weReg;
    assign flashWpN               = wpReg;
    assign flashByteN             = wordReg;
    assign resetPowerdownN        = rpReg;
    assign bootUnlockHighVoltage  = hhReg;
    assign idAccessHighVoltage    = vidReg;
    assign programSupplyHighLevel = vppReg;
endmodule
`default_nettype wire

/* File: core/bfh_pkg.sv */
// Package for the boot flash host controller: commands, widths and bus timing
package bfh_pkg;
    localparam int           ADDR_W         = 19;
    localparam int           DATA_W         = 16;
    localparam logic [7:0]   CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0]   CMD_CONFIRM     = 8'hD0;
    localparam logic [7:0]   CMD_WRITE_SETUP = 8'h40;
    localparam logic [7:0]   CMD_READ_ARRAY  = 8'hFF;
    localparam logic [7:0]   CMD_IDENTIFY    = 8'h90;
    // Strobe and recovery times in ns, with derived cycle counts at 100 MHz
    localparam int           CLK_PERIOD_NS  = 10;
    localparam int           STROBE_NS      = 90;
    localparam int           RECOVER_NS     = 30;
    localparam logic [3:0]   STROBE_CYC     = 4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0]   RECOVER_CYC    = 4'((RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0]   ONE_CYC        = 4'h1;
    localparam logic [15:0]  ZERO_WORD      = 16'h0000;
    // Host operation codes
    typedef enum logic [2:0] {
        OP_READ    = 3'h0,
        OP_ERASE   = 3'h1,
        OP_PROGRAM = 3'h2,
        OP_RDARRAY = 3'h3,
        OP_IDENT   = 3'h4
    } bfh_op_type;
    // Bus sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_WR1   = 6'b000010,
        ST_GAP   = 6'b000100,
        ST_WR2   = 6'b001000,
        ST_RD    = 6'b010000,
        ST_DONE  = 6'b100000
    } bfh_state_type;
endpackage

/* File: tb/bfh_flash_model.sv */
// Behavioural model of the dual-width boot flash on the host's pins
`timescale 1ns/1ps
`default_nettype none
module bfh_flash_model
    import bfh_pkg::*;
#(
    parameter logic [7:0]  MFR_CODE  = 8'h5A,
    parameter logic [7:0]  MFR_UPPER = 8'h12,
    parameter logic [7:0]  DEV_CODE  = 8'hA6,
    parameter logic [7:0]  DEV_UPPER = 8'h3C,
    parameter logic [18:0] BOOT_BASE = 19'h7E000
)(
    // Host pins
    input  wire logic [18:0] flashAddr,
    input  wire logic [15:0] flashDqOut,
    input  wire logic [15:0] flashDqOe,
    input  wire logic        flashCeN,
    input  wire logic        flashOeN,
    input  wire logic        flashWeN,
    input  wire logic        flashWpN,
    input  wire logic        flashByteN,
    input  wire logic        resetPowerdownN,
    input  wire logic        bootUnlockHighVoltage,
    input  wire logic        idAccessHighVoltage,
    input  wire logic        programSupplyHighLevel,
    // Resolved data bus and erase tally
    output logic [15:0]      flashDqIn,
    output var int           eraseCount
);
    logic [7:0]  mem [logic [19:0]];
    logic [7:0]  lastCmd = 8'hFF;
    logic        idMode  = 1'b0;
    logic        junk    = 1'b0;
    logic [15:0] devQ;
    wire logic   reading = resetPowerdownN && !flashCeN && !flashOeN && flashWeN;
    wire logic   bootOk  = flashAddr < BOOT_BASE || flashWpN || bootUnlockHighVoltage;
    initial eraseCount = 0;
    // Released lines wander so a stale value cannot pass
    always #7 junk = ~junk;
    function automatic logic [7:0] rdB(input logic [19:0] a);
        return mem.exists(a) ? mem[a] : 8'hFF;
    endfunction
    // Read path, refreshed at each read strobe
    always @(flashAddr, flashDqOut, flashByteN, idMode, idAccessHighVoltage, reading) begin
        if (idMode || (idAccessHighVoltage && flashAddr[9]))
            devQ = flashAddr[0] ? {DEV_UPPER, DEV_CODE} : {MFR_UPPER, MFR_CODE};
        else if (flashByteN)
            devQ = {rdB({flashAddr, 1'b1}), rdB({flashAddr, 1'b0})};
        else
            devQ = {8'h00, rdB({flashAddr, flashDqOut[15]})};
    end
    // Bus resolution: host, device or nobody
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            flashDqIn[i] = flashDqOe[i] ? flashDqOut[i] : (reading && (flashByteN || i < 8)) ? devQ[i] : junk;
        end
    end
    // Write cycles: commands on the low byte, then array data
    always @(negedge flashWeN) begin
        #20;
        if (!flashCeN && resetPowerdownN) begin
            if (lastCmd == 8'h40 || lastCmd == 8'h10) begin
                if (programSupplyHighLevel && bootOk && flashByteN) begin
                    mem[{flashAddr, 1'b0}] = flashDqIn[7:0];
                    mem[{flashAddr, 1'b1}] = flashDqIn[15:8];
                end else if (programSupplyHighLevel && bootOk)
                    mem[{flashAddr, flashDqIn[15]}] = flashDqIn[7:0];
                lastCmd = 8'h00;
            end else if (lastCmd == CMD_ERASE_SETUP) begin
                if (flashDqIn[7:0] == CMD_CONFIRM && programSupplyHighLevel && bootOk)
                    eraseCount++;
                lastCmd = 8'h00;
            end else begin
                lastCmd = flashDqIn[7:0];
                idMode = lastCmd == CMD_IDENTIFY || (idMode && lastCmd != CMD_READ_ARRAY);
            end
        end
    end
    // Power-down returns to array read
    always @(negedge resetPowerdownN) begin
        lastCmd = 8'hFF;
        idMode = 1'b0;
    end
endmodule
`default_nettype wire

/* File: tb/bfh_host_properties.sv */
// Concurrent checks on the boot flash host controller pins
`timescale 1ns/1ps
`default_nettype none
module bfh_host_checker
    import bfh_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // Flash pins
    input wire logic [18:0] flashAddr,
    input wire logic [15:0] flashDqOut,
    input wire logic [15:0] flashDqOe,
    input wire logic        flashCeN,
    input wire logic        flashOeN,
    input wire logic        flashWeN,
    input wire logic        flashByteN,
    input wire logic        resetPowerdownN,
    input wire logic        idAccessHighVoltage,
    input wire logic        programSupplyHighLevel
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Strobe relations
    strobe_excl_a: assert property (!(!flashOeN && !flashWeN))
        else $error("read and write strobes low together");
    write_select_a: assert property (!flashWeN |-> !flashCeN)
        else $error("write strobe without chip select");
    write_len_a: assert property ($fell(flashWeN) |=> (!flashWeN) [*8] ##1 flashWeN)
        else $error("write strobe length wrong");
    // Data line ownership
    read_release_a: assert property (!flashOeN |-> flashDqOe[14:0] == 15'h0000
        && flashDqOe[15] == !flashByteN && resetPowerdownN)
        else $error("host drives data during a read");
    byte_upper_a: assert property (!flashByteN |-> flashDqOe[14:8] == 7'h00)
        else $error("upper lines driven in byte mode");
    byte_addr_a: assert property (!flashByteN && (!flashWeN || !flashOeN) |-> flashDqOe[15])
        else $error("lowest address bit not driven in byte mode");
    // Command sequences
    confirm_supply_a: assert property (!flashWeN && !$fell(flashWeN) && flashDqOut[7:0] == CMD_CONFIRM
        |-> programSupplyHighLevel)
        else $error("confirm written without program supply");
    erase_pair_a: assert property ($rose(flashWeN) && $past(flashDqOut[7:0]) == CMD_ERASE_SETUP
        && !$past(programSupplyHighLevel) |-> ##[1:6] ($fell(flashWeN) && flashDqOut[7:0] == CMD_CONFIRM))
        else $error("erase setup not followed by confirm");
    id_addr_a: assert property (idAccessHighVoltage && !flashOeN
        |-> flashAddr[9] && flashAddr[8:1] == 8'h00 && flashAddr[18:10] == 9'h000)
        else $error("identity read address wrong");
    // Main scenarios reached
    cover property ($fell(flashWeN) && flashDqOut[7:0] == CMD_CONFIRM);
    cover property (!flashOeN && !flashByteN);
    cover property (idAccessHighVoltage && !flashOeN);
endmodule
bind bfh_host bfh_host_checker u_chk (.clk, .sys_rst, .flashAddr, .flashDqOut, .flashDqOe, .flashCeN, .flashOeN,
    .flashWeN, .flashByteN, .resetPowerdownN, .idAccessHighVoltage, .programSupplyHighLevel);
`default_nettype wire

/* File: tb/test_bfh_host.sv */
// Testbench for the boot flash host controller
`timescale 1ns/1ps
`default_nettype none
module test_bfh_host;
    import bfh_pkg::*;
    localparam logic [7:0] MFR = 8'h5A; // Arbitrary identity value
    localparam logic [7:0] MFRU = 8'h12; // Arbitrary identity value
    localparam logic [7:0] DEV = 8'hA6; // Arbitrary identity value
    localparam logic [7:0] DEVU = 8'h3C; // Arbitrary identity value
    logic clk = 1'b0, sys_rst = 1'b1, reqValid = 1'b0, reqWordMode = 1'b1, reqBootUnlock = 1'b0, reqIdByVoltage = 1'b0;
    bfh_op_type reqOp = OP_READ;
    logic [19:0] reqAddr = 20'h00000;
    logic [15:0] reqData = 16'h0000, got;
    wire logic reqReady, rspValid, flashCeN, flashOeN, flashWeN, flashWpN, flashByteN, resetPowerdownN;
    wire logic bootUnlockHighVoltage, idAccessHighVoltage, programSupplyHighLevel;
    wire logic [15:0] rspData, flashDqOut, flashDqOe, flashDqIn;
    wire logic [18:0] flashAddr;
    int eraseCount, base, err_count = 0, samples_checked = 0;
    always #5 clk = ~clk;
    bfh_host u_dut (.clk, .sys_rst, .reqValid, .reqOp, .reqAddr, .reqData, .reqWordMode, .reqBootUnlock,
        .reqIdByVoltage, .reqReady, .rspValid, .rspData, .flashAddr, .flashDqOut, .flashDqOe, .flashDqIn, .flashCeN,
        .flashOeN, .flashWeN, .flashWpN, .flashByteN, .resetPowerdownN, .bootUnlockHighVoltage, .idAccessHighVoltage,
        .programSupplyHighLevel);
    bfh_flash_model #(.MFR_CODE(MFR), .MFR_UPPER(MFRU), .DEV_CODE(DEV), .DEV_UPPER(DEVU)) u_flash (.flashAddr,
        .flashDqOut, .flashDqOe, .flashCeN, .flashOeN, .flashWeN, .flashWpN, .flashByteN, .resetPowerdownN,
        .bootUnlockHighVoltage, .idAccessHighVoltage, .programSupplyHighLevel, .flashDqIn, .eraseCount);
    task automatic end_of_test();
        if (err_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One request, then wait for the controller to come back to idle
    task automatic op(input bfh_op_type o, input logic [19:0] a, input logic [15:0] d, input logic w, u, v);
        int n;
        @(negedge clk);
        {reqOp, reqAddr, reqData, reqWordMode, reqBootUnlock, reqIdByVoltage} = {o, a, d, w, u, v};
        reqValid = 1'b1;
        @(negedge clk);
        reqValid = 1'b0;
        for (n = 0; n < 200 && reqReady !== 1'b1; n++) begin
            @(negedge clk);
            if (rspValid === 1'b1)
                got = rspData;
        end
        if (n == 200) begin
            err_count++;
            end_of_test();
        end
    endtask
    task automatic scn_word();
        op(OP_PROGRAM, 20'h00100, 16'hA55A, 1'b1, 1'b0, 1'b0);
        op(OP_RDARRAY, 20'h00000, 16'h0000, 1'b1, 1'b0, 1'b0);
        op(OP_READ, 20'h00100, 16'h0000, 1'b1, 1'b0, 1'b0);
        chk("word read", 16'hA55A, got);
    endtask
    task automatic scn_byte();
        op(OP_PROGRAM, 20'h00203, 16'h0037, 1'b0, 1'b0, 1'b0);
        op(OP_RDARRAY, 20'h00000, 16'h0000, 1'b0, 1'b0, 1'b0);
        op(OP_READ, 20'h00203, 16'h0000, 1'b0, 1'b0, 1'b0);
        chk("byte read", 16'h0037, {8'h00, got[7:0]});
        op(OP_READ, 20'h00202, 16'h0000, 1'b1, 1'b0, 1'b0);
        chk("word over byte", 16'h37FF, got);
    endtask
    task automatic scn_boot();
        base = eraseCount;
        op(OP_ERASE, 20'hFE000, 16'h0000, 1'b1, 1'b0, 1'b0);
        chk("locked boot erase", 16'(base), 16'(eraseCount));
        op(OP_ERASE, 20'hFE000, 16'h0000, 1'b1, 1'b1, 1'b0);
        chk("unlocked boot erase", 16'(base + 1), 16'(eraseCount));
        op(OP_ERASE, 20'h10000, 16'h0000, 1'b0, 1'b0, 1'b0);
        chk("main block erase", 16'(base + 2), 16'(eraseCount));
    endtask
    task automatic scn_ident();
        logic [15:0] exp;
        for (int i = 0; i < 8; i++) begin
            exp = i[2] ? {DEVU, DEV} : {MFRU, MFR};
            op(OP_IDENT, {19'h00000, i[2]}, 16'h0000, i[1], 1'b0, i[0]);
            if (i[1])
                chk("word identity", exp, got);
            else
                chk("byte identity", {8'h00, exp[7:0]}, {8'h00, got[7:0]});
        end
        op(OP_RDARRAY, 20'h00000, 16'h0000, 1'b1, 1'b0, 1'b0);
    endtask
    initial begin
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge clk);
        scn_word();
        scn_byte();
        scn_boot();
        scn_ident();
        end_of_test();
    end
endmodule
`default_nettype wire
